/* File: src/pdsr_regs.v */
// PECI domain selection and status register bank with a classic Wishbone slave
//
// Operation
// - Domain register bits 7..4 mark agents 4..1 as having a second domain.
// - With return-high set, each agent with a second domain reports the higher of its two domains.
// - Otherwise each agent with a second domain has its return-domain bit pick domain 0 or domain 1.
// - Bank 1 turns the domain register location into agent 3 high byte.
// - Agent 4 temperature reads as low then high read-only bytes in both banks.
// - Flag register bit 3 selects bank: 0 config and alerts, 1 temps and absent.
// - Bank 0 flags show an agent had a bad FCS in its last 3 transactions that were not absent.
// - Bank 1 flags show an agent cannot be detected on the wire.
// - Absent flags sit at bits 7..4 for agents 4..1.
// - Bank 1 relative temperatures read as low/high pairs, agents 1 to 4 in order.
// - Domain and flag registers reset to zero, bank 0 selected.
// - A return-domain bit acts only while that agent's second domain is enabled.
// - Agents 1 to 4 are PECI targets 0x30 to 0x33.
`timescale 1ns/10ps
`include "pdsr_consts.vh"
module pdsr_regs (
  input  wire        MCLK,
  input  wire        ARST_N,
  // Classic Wishbone slave
  input  wire        CYC_I,
  input  wire        STB_I,
  input  wire        WE_I,
  input  wire [11:0] ADR_I,
  input  wire [3:0]  SEL_I,
  input  wire [31:0] DAT_I,
  output reg  [31:0] DAT_O,
  output reg         ACK_O,
  // Return-domain bits held in the agent configuration register elsewhere
  input  wire [3:0]  RETURN_DOMAIN_SEL,
  // Transaction results from the PECI poller, one-cycle strobe
  input  wire        XACT_DONE,
  input  wire [7:0]  XACT_TARGET,
  input  wire        XACT_DOMAIN,
  input  wire        XACT_FCS_BAD,
  input  wire        XACT_ABSENT,
  input  wire [15:0] XACT_TEMP,
  // Settings and results toward the poller and the fan logic
  output reg  [3:0]  SECOND_DOMAIN_EN,
  output reg         RETURN_HIGH,
  output reg  [3:0]  AGENT_ALERT,
  output reg  [3:0]  AGENT_ABSENT,
  output reg  [15:0] FIRST_TARGET_RELATIVE_TEMP,
  output reg  [15:0] SECOND_TARGET_RELATIVE_TEMP,
  output reg  [15:0] THIRD_TARGET_RELATIVE_TEMP,
  output reg  [15:0] FOURTH_TARGET_RELATIVE_TEMP
);

  // Maps a PECI target address to a one-hot agent select; other targets map to none
  function [3:0] agent_of;
    input [7:0] addr;
    begin
      case (addr)
        `PDSR_AGENT1_ADDR: agent_of = 4'h1;
        `PDSR_AGENT2_ADDR: agent_of = 4'h2;
        `PDSR_AGENT3_ADDR: agent_of = 4'h4;
        `PDSR_AGENT4_ADDR: agent_of = 4'h8;
        default:           agent_of = 4'h0;
      endcase
    end
  endfunction

  // Control registers
  reg  [3:0]  d1_en_q;
  reg         ret_high_q;
  reg         bank_q;
  reg  [3:0]  absent_q;
  reg         ack_q;
  reg  [7:0]  rd_q;

  // Domain temperatures per agent, addressed by agent index
  reg  [15:0] dom0_q [0:3];
  reg  [15:0] dom1_q [0:3];
  reg  [15:0] rel_q  [0:3];

  wire        req;
  wire        wr_take;
  wire [9:0]  idx;
  wire [3:0]  hit;
  wire [3:0]  xact_ok;
  wire [3:0]  fcs_upd;
  wire [3:0]  alert_w;
  wire [15:0] pick_w [0:3];
  wire [7:0]  domain_view;
  wire [7:0]  flags_view;
  reg  [7:0]  rd_d;
  integer     i;

  assign req = CYC_I & STB_I;
  assign idx = ADR_I[11:2];
  // A write lands on the same edge that the master sees the acknowledge
  assign wr_take = req & ack_q & WE_I & SEL_I[0];

  assign hit = XACT_DONE ? agent_of(XACT_TARGET) : 4'h0;
  // Only a detected agent's transaction counts toward the FCS history
  assign fcs_upd = hit & {4{~XACT_ABSENT}};
  assign xact_ok = fcs_upd & {4{~XACT_FCS_BAD}};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : agent
      pdsr_temp_pick u_pick (
        .dom0_temp (dom0_q[g]),
        .dom1_temp (dom1_q[g]),
        .dom1_en   (d1_en_q[g]),
        .ret_dom1  (RETURN_DOMAIN_SEL[g]),
        .ret_high  (ret_high_q),
        .pick_temp (pick_w[g])
      );
      pdsr_fcs_hist u_fcs (
        .clk     (MCLK),
        .rst_n   (ARST_N),
        .upd     (fcs_upd[g]),
        .fcs_bad (XACT_FCS_BAD),
        .alert   (alert_w[g])
      );
    end
  endgenerate

  assign domain_view = {d1_en_q, 2'b00, ret_high_q, 1'b0};
  assign flags_view  = bank_q ? {absent_q, bank_q, 3'b000}
                              : {alert_w, bank_q, 3'b000};

  // Read mux; the bank bit remaps the low locations onto the temperatures
  always @* begin
    rd_d = 8'h00;
    case (idx)
      `PDSR_IDX_AG1_LO: rd_d = bank_q ? rel_q[0][7:0]  : 8'h00;
      `PDSR_IDX_AG1_HI: rd_d = bank_q ? rel_q[0][15:8] : 8'h00;
      `PDSR_IDX_AG2_LO: rd_d = bank_q ? rel_q[1][7:0]  : 8'h00;
      `PDSR_IDX_AG2_HI: rd_d = bank_q ? rel_q[1][15:8] : 8'h00;
      `PDSR_IDX_AG3_LO: rd_d = bank_q ? rel_q[2][7:0]  : 8'h00;
      `PDSR_IDX_DOMAIN: rd_d = bank_q ? rel_q[2][15:8] : domain_view;
      `PDSR_IDX_AG4_LO: rd_d = rel_q[3][7:0];
      `PDSR_IDX_AG4_HI: rd_d = rel_q[3][15:8];
      `PDSR_IDX_FLAGS:  rd_d = flags_view;
      default:          rd_d = 8'h00;
    endcase
  end

  // Bus handshake: one wait state, acknowledge dropped after one cycle
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_q <= 1'b0;
      rd_q  <= 8'h00;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        rd_q <= rd_d;
      end
    end
  end

  // Host-writable settings
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      d1_en_q    <= `PDSR_D1EN_RST;
      ret_high_q <= `PDSR_RETHI_RST;
      bank_q     <= `PDSR_BANK_RST;
    end else if (wr_take) begin
      // The domain location is a read window in bank 1, so writes there are dropped
      if (idx == `PDSR_IDX_DOMAIN && !bank_q) begin
        d1_en_q    <= DAT_I[`PDSR_DOM_D1EN_LSB+3:`PDSR_DOM_D1EN_LSB];
        ret_high_q <= DAT_I[`PDSR_DOM_RETHI_BIT];
      end
      if (idx == `PDSR_IDX_FLAGS) begin
        bank_q <= DAT_I[`PDSR_FLG_BANK_BIT];
      end
    end
  end

  // Poller results: only these update absent flags and domain temperatures
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      absent_q <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        dom0_q[i] <= `PDSR_TEMP_RST;
        dom1_q[i] <= `PDSR_TEMP_RST;
        rel_q[i]  <= `PDSR_TEMP_RST;
      end
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (hit[i]) begin
          absent_q[i] <= XACT_ABSENT;
        end
        if (xact_ok[i] && !XACT_DOMAIN) begin
          dom0_q[i] <= XACT_TEMP;
        end
        // A domain 1 answer is kept only for agents declared to have one
        if (xact_ok[i] && XACT_DOMAIN && d1_en_q[i]) begin
          dom1_q[i] <= XACT_TEMP;
        end
        rel_q[i] <= pick_w[i];
      end
    end
  end

  // Registered outputs
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DAT_O                       <= 32'h0000_0000;
      ACK_O                       <= 1'b0;
      SECOND_DOMAIN_EN            <= 4'h0;
      RETURN_HIGH                 <= 1'b0;
      AGENT_ALERT                 <= 4'h0;
      AGENT_ABSENT                <= 4'h0;
      FIRST_TARGET_RELATIVE_TEMP  <= `PDSR_TEMP_RST;
      SECOND_TARGET_RELATIVE_TEMP <= `PDSR_TEMP_RST;
      THIRD_TARGET_RELATIVE_TEMP  <= `PDSR_TEMP_RST;
      FOURTH_TARGET_RELATIVE_TEMP <= `PDSR_TEMP_RST;
    end else begin
      DAT_O                       <= (req & ~ack_q) ? {24'h00_0000, rd_d} : {24'h00_0000, rd_q};
      ACK_O                       <= req & ~ack_q;
      SECOND_DOMAIN_EN            <= d1_en_q;
      RETURN_HIGH                 <= ret_high_q;
      AGENT_ALERT                 <= alert_w;
      AGENT_ABSENT                <= absent_q;
      FIRST_TARGET_RELATIVE_TEMP  <= rel_q[0];
      SECOND_TARGET_RELATIVE_TEMP <= rel_q[1];
      THIRD_TARGET_RELATIVE_TEMP  <= rel_q[2];
      FOURTH_TARGET_RELATIVE_TEMP <= rel_q[3];
    end
  end

endmodule

/* File: src/pdsr_consts.vh */
// Offsets, field positions, reset values and agent addresses of the PECI domain/status bank
`ifndef PDSR_CONSTS_VH
`define PDSR_CONSTS_VH

// Register indexes; the byte address on the bus is four times the index
`define PDSR_IDX_AG1_LO      10'h0e0
`define PDSR_IDX_AG1_HI      10'h0e1
`define PDSR_IDX_AG2_LO      10'h0e2
`define PDSR_IDX_AG2_HI      10'h0e3
`define PDSR_IDX_AG3_LO      10'h0e4
`define PDSR_IDX_DOMAIN      10'h0e5
`define PDSR_IDX_AG4_LO      10'h0e6
`define PDSR_IDX_AG4_HI      10'h0e7
`define PDSR_IDX_FLAGS       10'h0e8

// Field positions
`define PDSR_DOM_D1EN_LSB    4
`define PDSR_DOM_RETHI_BIT   1
`define PDSR_FLG_AGENT_LSB   4
`define PDSR_FLG_BANK_BIT    3

// Reset values
`define PDSR_DOMAIN_RST      8'h00
`define PDSR_FLAGS_RST       8'h00
`define PDSR_TEMP_RST        16'h0000
`define PDSR_D1EN_RST        4'h0
`define PDSR_RETHI_RST       1'b0
`define PDSR_BANK_RST        1'b0

// PECI target addresses of agents 1 to 4
`define PDSR_AGENT1_ADDR     8'h30
`define PDSR_AGENT2_ADDR     8'h31
`define PDSR_AGENT3_ADDR     8'h32
`define PDSR_AGENT4_ADDR     8'h33

// Number of recent transactions watched for a bad FCS
`define PDSR_FCS_DEPTH       3

`endif

/* File: src/pdsr_temp_pick.v */
// Per-agent choice of the reported relative temperature from domain 0 and domain 1
`timescale 1ns/10ps
module pdsr_temp_pick (
  input  wire [15:0] dom0_temp,
  input  wire [15:0] dom1_temp,
  input  wire        dom1_en,
  input  wire        ret_dom1,
  input  wire        ret_high,
  output wire [15:0] pick_temp
);

  // Relative temperatures are two's complement, so the compare is signed
  function [15:0] signed_max;
    input [15:0] a;
    input [15:0] b;
    begin
      signed_max = ($signed(a) >= $signed(b)) ? a : b;
    end
  endfunction

  wire [15:0] by_sel;
  wire [15:0] by_high;

  assign by_sel    = (dom1_en & ret_dom1) ? dom1_temp : dom0_temp;
  // An agent without domain 1 has nothing to compare against
  assign by_high   = dom1_en ? signed_max(dom0_temp, dom1_temp) : dom0_temp;
  assign pick_temp = ret_high ? by_high : by_sel;

endmodule

/* File: src/pdsr_fcs_hist.v */
// Per-agent history of FCS results over the most recent transactions
`timescale 1ns/10ps
`include "pdsr_consts.vh"
module pdsr_fcs_hist (
  input  wire clk,
  input  wire rst_n,
  input  wire upd,
  input  wire fcs_bad,
  output reg  alert
);

  reg [`PDSR_FCS_DEPTH-1:0] hist_q;
  reg [`PDSR_FCS_DEPTH-1:0] hist_d;

  always @* begin
    hist_d = hist_q;
    if (upd) begin
      hist_d = {hist_q[`PDSR_FCS_DEPTH-2:0], fcs_bad};
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_q <= {`PDSR_FCS_DEPTH{1'b0}};
      alert  <= 1'b0;
    end else begin
      hist_q <= hist_d;
      alert  <= |hist_d;
    end
  end

endmodule

/* File: tb/pdsr_checker.sv */
// Port-level assertions of the PECI domain/status bank
`timescale 1ns/10ps
module pdsr_checker (
  input wire        MCLK,
  input wire        ARST_N,
  input wire        CYC_I,
  input wire        STB_I,
  input wire [31:0] DAT_O,
  input wire        ACK_O,
  input wire        XACT_DONE,
  input wire [7:0]  XACT_TARGET,
  input wire        XACT_DOMAIN,
  input wire        XACT_FCS_BAD,
  input wire        XACT_ABSENT,
  input wire [15:0] XACT_TEMP,
  input wire [3:0]  SECOND_DOMAIN_EN,
  input wire [3:0]  AGENT_ALERT,
  input wire [3:0]  AGENT_ABSENT,
  input wire [15:0] THIRD_TARGET_RELATIVE_TEMP
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  wire req = CYC_I & STB_I;
  wire ok  = XACT_DONE & ~XACT_ABSENT;
  a_ack_pulse: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
  a_ack_answer: assert property (req && !ACK_O |=> ACK_O) else $error("no ack");
  a_ack_cause: assert property (!req |=> !ACK_O) else $error("stray ack");
  a_read_width: assert property (ACK_O |-> DAT_O[31:8] == 24'h0) else $error("upper data");
  a_absent_set: assert property (
    XACT_DONE && XACT_ABSENT && XACT_TARGET == 8'h33 |-> ##[1:2] AGENT_ABSENT[3])
    else $error("absent flag");
  a_alert_set: assert property (
    ok && XACT_FCS_BAD && XACT_TARGET == 8'h31 |-> ##[1:2] AGENT_ALERT[1])
    else $error("alert flag");
  a_flags_hold: assert property (
    !XACT_DONE && !$past(XACT_DONE) |=> $stable(AGENT_ALERT) && $stable(AGENT_ABSENT))
    else $error("flags moved");
  a_temp_dom0: assert property (
    ok && !XACT_FCS_BAD && XACT_TARGET == 8'h32 && !XACT_DOMAIN && !SECOND_DOMAIN_EN[2]
    |-> ##3 THIRD_TARGET_RELATIVE_TEMP == $past(XACT_TEMP, 3)) else $error("agent3 temp");
  a_reset_zero: assert property (disable iff (1'b0)
    !ARST_N |-> SECOND_DOMAIN_EN == 4'h0 && AGENT_ALERT == 4'h0 && !ACK_O)
    else $error("reset value");
  c_bad_fcs: cover property (ok && XACT_FCS_BAD);
  c_absent: cover property (XACT_DONE && XACT_ABSENT);
  c_bus: cover property (req && ACK_O);
endmodule

bind pdsr_regs pdsr_checker chk (
  .MCLK, .ARST_N, .CYC_I, .STB_I, .DAT_O, .ACK_O, .XACT_DONE, .XACT_TARGET,
  .XACT_DOMAIN, .XACT_FCS_BAD, .XACT_ABSENT, .XACT_TEMP, .SECOND_DOMAIN_EN,
  .AGENT_ALERT, .AGENT_ABSENT, .THIRD_TARGET_RELATIVE_TEMP
);

/* File: tb/pdsr_agent_model.sv */
// Behavioural feed of PECI agent transaction results
`timescale 1ns/10ps
module pdsr_agent_model (
  input  wire        clk,
  output reg         done = 1'b0,
  output reg  [7:0]  target = 8'h00,
  output reg         domain = 1'b0,
  output reg         fcs_bad = 1'b0,
  output reg         absent = 1'b0,
  output reg  [15:0] temp = 16'h0
);
  // Target and temp are stale after the strobe, so they flip; the other qualifiers hold
  task send(input [7:0] t, input d, input b, input a, input [15:0] v);
    begin
      @(posedge clk);
      done    <= 1'b1;
      target  <= t;
      domain  <= d;
      fcs_bad <= b;
      absent  <= a;
      temp    <= v;
      @(posedge clk);
      done    <= 1'b0;
      target  <= ~t;
      temp    <= ~v;
    end
  endtask
endmodule

/* File: tb/pdsr_regs_tb.sv */
// Self-checking bench of the PECI domain/status register bank
`timescale 1ns/10ps
module pdsr_regs_tb;
  reg         mclk = 1'b0;
  reg         arst_n = 1'b0;
  reg         cyc = 1'b0;
  reg         we = 1'b0;
  reg  [11:0] adr = 12'h000;
  reg  [31:0] wd = 32'h0;
  reg  [3:0]  rds = 4'h0;
  wire [31:0] rd;
  wire        ack, xd, xdom, xbad, xabs;
  wire [7:0]  xt;
  wire [15:0] xv;
  reg  [15:0] t[0:5];
  reg  [15:0] ex[0:3];
  reg  [15:0] mx;
  wire [15:0] p4;
  wire [3:0]  sde;
  wire        rh;
  reg  [7:0]  expq[$];
  integer     fails = 0;
  integer     n_checks = 0;

  pdsr_regs dut (
    .MCLK(mclk), .ARST_N(arst_n), .CYC_I(cyc), .STB_I(cyc), .WE_I(we),
    .ADR_I(adr), .SEL_I(4'h1), .DAT_I(wd), .DAT_O(rd), .ACK_O(ack),
    .RETURN_DOMAIN_SEL(rds), .XACT_DONE(xd), .XACT_TARGET(xt), .XACT_DOMAIN(xdom),
    .XACT_FCS_BAD(xbad), .XACT_ABSENT(xabs), .XACT_TEMP(xv), .SECOND_DOMAIN_EN(sde),
    .RETURN_HIGH(rh), .AGENT_ALERT(), .AGENT_ABSENT(), .FIRST_TARGET_RELATIVE_TEMP(),
    .SECOND_TARGET_RELATIVE_TEMP(), .THIRD_TARGET_RELATIVE_TEMP(),
    .FOURTH_TARGET_RELATIVE_TEMP(p4)
  );
  pdsr_agent_model ag (
    .clk(mclk), .done(xd), .target(xt), .domain(xdom), .fcs_bad(xbad),
    .absent(xabs), .temp(xv)
  );

  task bus(input [7:0] i, input w, input [7:0] d, input [7:0] e);
    begin
      @(posedge mclk);
      cyc <= 1'b1;
      we  <= w;
      adr <= {2'b00, i, 2'b00};
      wd  <= {24'h0, d};
      if (!w)
        expq.push_back(e);
      @(posedge mclk);
      while (!ack)
        @(posedge mclk);
      cyc <= 1'b0;
    end
  endtask

  // Port compare for outputs that stand as levels
  task chk(input [15:0] e, input [15:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("wrong value port exp %h got %h", e, g);
      end
    end
  endtask

  task print_verdict;
    begin
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  always @(posedge mclk)
    if (ack && !we) begin
      n_checks = n_checks + 1;
      if (rd[7:0] !== expq[0]) begin
        fails = fails + 1;
        $display("wrong value reg %h exp %h got %h", adr[9:2], expq[0], rd[7:0]);
      end
      void'(expq.pop_front());
    end

  initial forever #2.5 mclk = ~mclk;

  initial begin
    #20000;
    fails = fails + 1;
    print_verdict;
  end

  initial begin
    t[0] = $urandom(83);
    for (int k = 0; k < 6; k++)
      t[k] = $urandom;
    ex[0] = t[1];
    ex[1] = t[2];
    ex[2] = t[4];
    ex[3] = t[5];
    mx = ($signed(t[0]) > $signed(t[1])) ? t[0] : t[1];
    rds <= {t[5][1:0], 2'b11};
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    bus(8'he5, 0, 8'h00, 8'h00);
    bus(8'he8, 0, 8'h00, 8'h00);
    bus(8'he5, 1, 8'hff, 8'h00);
    bus(8'he5, 0, 8'h00, 8'hf2);
    bus(8'h00, 0, 8'h00, 8'h00);
    bus(8'he5, 1, 8'h10, 8'h00);
    ag.send(8'h30, 0, 0, 0, t[0]);
    ag.send(8'h30, 1, 0, 0, t[1]);
    ag.send(8'h31, 0, 0, 0, t[2]);
    ag.send(8'h31, 1, 0, 0, t[3]);
    ag.send(8'h32, 0, 0, 0, t[4]);
    ag.send(8'h33, 0, 0, 0, t[5]);
    ag.send(8'h34, 0, 0, 0, t[3]);
    repeat (3) @(posedge mclk);
    chk(ex[3], p4);
    chk(16'h0001, {12'h000, sde});
    chk(16'h0000, {15'h0000, rh});
    bus(8'he8, 1, 8'h08, 8'h00);
    for (int k = 0; k < 4; k++) begin
      bus(8'(8'he0 + 2 * k), 0, 8'h00, ex[k][7:0]);
      bus(8'(8'he1 + 2 * k), 0, 8'h00, ex[k][15:8]);
    end
    bus(8'he5, 1, 8'hff, 8'h00);
    bus(8'he8, 1, 8'h00, 8'h00);
    bus(8'he5, 0, 8'h00, 8'h10);
    bus(8'he5, 1, 8'h12, 8'h00);
    bus(8'he8, 1, 8'h08, 8'h00);
    bus(8'he0, 0, 8'h00, mx[7:0]);
    bus(8'he1, 0, 8'h00, mx[15:8]);
    bus(8'he8, 1, 8'h00, 8'h00);
    ag.send(8'h31, 0, 1, 0, t[2]);
    bus(8'he8, 0, 8'h00, 8'h20);
    for (int k = 0; k < 3; k++) begin
      ag.send(8'h31, 0, 0, 0, t[2]);
      bus(8'he8, 0, 8'h00, (k < 2) ? 8'h20 : 8'h00);
    end
    bus(8'he8, 1, 8'hf8, 8'h00);
    ag.send(8'h33, 0, 0, 1, t[5]);
    bus(8'he8, 0, 8'h00, 8'h88);
    print_verdict;
  end
endmodule
